/* File: rtl/power_mode_controller.sv */
// Power-mode controller: clock selection, halt states and status flags
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Notes on behaviour
// - Run clock follows select bit and divider; low power only on halt.
// - On slow source the fast oscillator and its /16, /64 clocks stop.
// - Select low with divider 000 or 001 runs from the slow oscillator.
// - Switch to slow completes only after the slow ready flag rises.
// - Select high or divider 010..111 returns to the fast clock.
// - Fast ready flag shows fast oscillator stability; software polls it.
// - Halt, idle off, watchdog and detector off enters deep sleep.
// - Deep sleep stops system, watchdog and time base clocks; CPU held.
// - Entering deep sleep clears and stops the watchdog counter.
// - Low-power states leave memory, registers and port levels untouched.
// - Entering any low-power state sets power-down, clears timeout flag unless a timeout arrives in the same cycle.
// - Halt, idle off, watchdog or detector on enters light sleep.
// - Light sleep stops system and time base; sub clock runs, watchdog only if sub-clocked.
// - Light sleep clears watchdog; sub-clocked enabled watchdog keeps counting.
// - Halt, idle on, keep-sysclk off enters clock-stopped idle.
// - Clock-stopped idle stops system clock; time base and sub clock run.
// - Clock-stopped idle clears watchdog; only sub-clocked watchdog counts.
// - Halt, idle on, keep-sysclk on enters clock-running idle.
// - Clock-running idle keeps system, time base, sub clock; CPU held.
// - Clock-running idle clears watchdog; enabled watchdog keeps counting.
// - Divider picks slow source or fast clock divided by 64 down to 2.
// - Fast ready rises 1024 cycles (crystal) or 16 cycles (RC) later.
// - Slow ready low in deep sleep; rises 1024 or 2 cycles after wake.
// ----------------------------------------------------------------
module power_mode_controller
    import power_mode_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic halt_exec,
    input wire logic wake_req,
    input wire logic wdt_clear_instr,
    input wire logic wdt_timeout,
    output logic fast_osc_en,
    output logic slow_osc_en,
    output logic fast_div_taps_en,
    output logic sysclk_on_slow,
    output logic [2:0] sysclk_div_sel,
    output logic sysclk_run,
    output logic timebase_clk_run,
    output logic sub_clk_run,
    output logic wdt_clk_run,
    output logic wdt_clear,
    output logic cpu_hold,
    output logic io_hold
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pm_state_e state_r, state_nxt;
    logic [2:0] div_r, div_nxt;
    logic idle_en_r, idle_en_nxt;
    logic fast_sel_r, fast_sel_nxt;
    logic keep_sys_r, keep_sys_nxt;
    logic [2:0] period_r, period_nxt;
    logic [3:0] wdt_en_r, wdt_en_nxt;
    logic [3:0] opt_r, opt_nxt;
    logic pdn_r, pdn_nxt;
    logic to_r, to_nxt;
    logic on_slow_r, on_slow_nxt;
    logic [10:0] fast_cnt_r, fast_cnt_nxt;
    logic [10:0] slow_cnt_r, slow_cnt_nxt;
    logic fast_rdy_r, fast_rdy_nxt;
    logic slow_rdy_r, slow_rdy_nxt;
    logic wdt_clear_r, wdt_clear_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;

    logic bus_req, bus_wr, wdt_on, vd_on, want_slow;
    logic fast_need, slow_need;
    logic [10:0] fast_lim, slow_lim;

    // Divider code asks for the slow oscillator
    function automatic logic div_is_slow(input logic [2:0] d);
        div_is_slow = (d < DIV_FIRST_FAST);
    endfunction

    // Settling counter step: counts while enabled, restarts when off
    function automatic logic [10:0] settle_step(input logic en,
                                                input logic [10:0] cnt,
                                                input logic [10:0] lim);
        if (!en)
            settle_step = 11'h000;
        else if (cnt < lim)
            settle_step = cnt + 11'h001;
        else
            settle_step = cnt;
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign wdt_on = (wdt_en_r != WDT_OFF_CODE);
    assign vd_on = opt_r[OP_VD_EN];
    assign want_slow = !fast_sel_r && div_is_slow(div_r);
    assign fast_lim = opt_r[OP_FAST_XTAL] ? FAST_XTAL_CYC : FAST_RC_CYC;
    assign slow_lim = opt_r[OP_SLOW_XTAL] ? SLOW_XTAL_CYC : SLOW_RC_CYC;

    // Fast oscillator stops when parked on slow, and in both sleeps and
    // clock-stopped idle; in clock-running idle it runs unless on slow.
    always_comb
    begin
        fast_need = 1'b0;
        slow_need = 1'b1;
        case (state_r)
            ST_RUN, ST_IDLE_RUN:
            begin
                fast_need = !(on_slow_r && want_slow);
            end
            ST_DEEP_SLEEP:
            begin
                slow_need = 1'b0;
            end
            default:
            begin
                fast_need = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        div_nxt = div_r;
        idle_en_nxt = idle_en_r;
        fast_sel_nxt = fast_sel_r;
        keep_sys_nxt = keep_sys_r;
        period_nxt = period_r;
        wdt_en_nxt = wdt_en_r;
        opt_nxt = opt_r;
        pdn_nxt = pdn_r;
        to_nxt = to_r;
        on_slow_nxt = on_slow_r;
        wdt_clear_nxt = 1'b0;
        ack_nxt = bus_req;
        rdat_nxt = rdat_r;

        // Register writes; nothing here is touched by mode changes
        if (bus_wr)
        begin
            case (wb_adr_i)
                ADDR_SYS_MODE:
                begin
                    div_nxt = wb_dat_i[SM_DIV_LSB +: 3];
                    idle_en_nxt = wb_dat_i[SM_IDLE_EN];
                    fast_sel_nxt = wb_dat_i[SM_FAST_SEL];
                end
                ADDR_WDT_CTRL:
                begin
                    keep_sys_nxt = wb_dat_i[WC_KEEP_SYS];
                    period_nxt = wb_dat_i[WC_PERIOD_LSB +: 3];
                    wdt_en_nxt = wb_dat_i[3:0];
                end
                ADDR_OPTIONS:
                begin
                    opt_nxt = wb_dat_i[3:0];
                end
                default:
                begin
                    opt_nxt = opt_r;
                end
            endcase
        end

        if (bus_req)
        begin
            case (wb_adr_i)
                ADDR_SYS_MODE:
                    rdat_nxt = {24'h00_0000, div_r, 1'b0, slow_rdy_r,
                                fast_rdy_r, idle_en_r, fast_sel_r};
                ADDR_WDT_CTRL:
                    rdat_nxt = {24'h00_0000, keep_sys_r, period_r, wdt_en_r};
                ADDR_STATUS:
                    rdat_nxt = {24'h00_0000, on_slow_r, state_r, to_r, pdn_r};
                ADDR_OPTIONS:
                    rdat_nxt = {28'h000_0000, opt_r};
                default:
                    rdat_nxt = 32'h0000_0000;
            endcase
        end

        // Switch source only once the target oscillator has settled
        if (want_slow && slow_rdy_r)
            on_slow_nxt = 1'b1;
        else if (!want_slow && fast_rdy_r)
            on_slow_nxt = 1'b0;

        // Power-down flag: the clear instruction clears it, halt sets it
        if (wdt_clear_instr)
            pdn_nxt = 1'b0;
        if (wdt_timeout)
            to_nxt = 1'b1;

        case (state_r)
            ST_RUN:
            begin
                if (halt_exec)
                begin
                    wdt_clear_nxt = 1'b1;
                    pdn_nxt = 1'b1;
                    // A timeout in the same cycle is kept
                    to_nxt = wdt_timeout;
                    if (!idle_en_r && !wdt_on && !vd_on)
                        state_nxt = ST_DEEP_SLEEP;
                    else if (!idle_en_r)
                        state_nxt = ST_LIGHT_SLEEP;
                    else if (!keep_sys_r)
                        state_nxt = ST_IDLE_STOP;
                    else
                        state_nxt = ST_IDLE_RUN;
                end
            end
            ST_DEEP_SLEEP, ST_LIGHT_SLEEP, ST_IDLE_STOP, ST_IDLE_RUN:
            begin
                if (wake_req)
                    state_nxt = ST_RUN;
            end
            default:
            begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // Oscillator settling
    always_comb
    begin
        fast_cnt_nxt = settle_step(fast_need, fast_cnt_r, fast_lim);
        slow_cnt_nxt = settle_step(slow_need, slow_cnt_r, slow_lim);
        fast_rdy_nxt = fast_need && (fast_cnt_r >= fast_lim);
        slow_rdy_nxt = slow_need && (slow_cnt_r >= slow_lim);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_r <= ST_RUN;
            div_r <= DIV_RST;
            idle_en_r <= IDLE_EN_RST;
            fast_sel_r <= FAST_SEL_RST;
            keep_sys_r <= KEEP_SYS_RST;
            period_r <= PERIOD_RST;
            wdt_en_r <= WDT_EN_RST;
            opt_r <= OPT_RST;
            pdn_r <= 1'b0;
            to_r <= 1'b0;
            on_slow_r <= 1'b0;
            fast_cnt_r <= 11'h000;
            slow_cnt_r <= 11'h000;
            fast_rdy_r <= 1'b0;
            slow_rdy_r <= 1'b0;
            wdt_clear_r <= 1'b0;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            idle_en_r <= idle_en_nxt;
            fast_sel_r <= fast_sel_nxt;
            keep_sys_r <= keep_sys_nxt;
            period_r <= period_nxt;
            wdt_en_r <= wdt_en_nxt;
            opt_r <= opt_nxt;
            pdn_r <= pdn_nxt;
            to_r <= to_nxt;
            on_slow_r <= on_slow_nxt;
            fast_cnt_r <= fast_cnt_nxt;
            slow_cnt_r <= slow_cnt_nxt;
            fast_rdy_r <= fast_rdy_nxt;
            slow_rdy_r <= slow_rdy_nxt;
            wdt_clear_r <= wdt_clear_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign fast_osc_en = fast_need;
    assign fast_div_taps_en = fast_need;
    assign slow_osc_en = slow_need;
    assign sysclk_on_slow = on_slow_r;
    assign sysclk_div_sel = div_r;
    assign wdt_clear = wdt_clear_r;
    assign cpu_hold = (state_r != ST_RUN);
    // Ports keep their level in every low-power state
    assign io_hold = cpu_hold;

    always_comb
    begin
        sysclk_run = 1'b0;
        timebase_clk_run = 1'b0;
        sub_clk_run = 1'b1;
        wdt_clk_run = 1'b0;
        case (state_r)
            ST_RUN:
            begin
                sysclk_run = 1'b1;
                timebase_clk_run = 1'b1;
                wdt_clk_run = wdt_on;
            end
            ST_DEEP_SLEEP:
            begin
                sub_clk_run = 1'b0;
            end
            ST_LIGHT_SLEEP:
            begin
                wdt_clk_run = wdt_on && opt_r[OP_WDT_SUB];
            end
            ST_IDLE_STOP:
            begin
                timebase_clk_run = 1'b1;
                wdt_clk_run = wdt_on && opt_r[OP_WDT_SUB];
            end
            ST_IDLE_RUN:
            begin
                sysclk_run = 1'b1;
                timebase_clk_run = 1'b1;
                wdt_clk_run = wdt_on;
            end
            default:
            begin
                sub_clk_run = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_halt_leaves_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_RUN && !halt_exec) |=> (state_r == ST_RUN))
        else $error("Left run state without halt");
    a_slow_stops_fast: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (on_slow_r && want_slow) |-> (!fast_osc_en && !fast_div_taps_en))
        else $error("Fast oscillator on while parked on slow clock");
    a_slow_after_ready: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(on_slow_r) |-> $past(slow_rdy_r) && $past(want_slow))
        else $error("Moved to slow clock before it settled");
    a_fast_return: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(on_slow_r) |-> $past(fast_rdy_r) && !$past(want_slow))
        else $error("Returned to fast clock before it settled");
    a_deep_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_RUN && halt_exec && !idle_en_r && !wdt_on && !vd_on)
        |=> (state_r == ST_DEEP_SLEEP) && wdt_clear && !wdt_clk_run)
        else $error("Deep sleep entry wrong");
    a_light_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_RUN && halt_exec && !idle_en_r && (wdt_on || vd_on))
        |=> (state_r == ST_LIGHT_SLEEP) && !sysclk_run)
        else $error("Light sleep entry wrong");
    a_idle_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_RUN && halt_exec && idle_en_r)
        |=> (state_r == (keep_sys_r ? ST_IDLE_RUN : ST_IDLE_STOP)))
        else $error("Idle entry wrong");
    a_flags_on_halt: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_RUN && halt_exec && !wdt_timeout)
        |=> pdn_r && !to_r && cpu_hold)
        else $error("Flags not updated on halt");
    a_deep_clocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_DEEP_SLEEP) |-> !sysclk_run && !timebase_clk_run
        && !sub_clk_run && !slow_osc_en ##1 !slow_rdy_r)
        else $error("Clocks running in deep sleep");
    a_idle_run_clocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r == ST_IDLE_RUN) |-> sysclk_run && timebase_clk_run
        && (wdt_clk_run == wdt_on))
        else $error("Clock-running idle clocks wrong");
    a_fast_settle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ($rose(fast_osc_en) && !opt_r[OP_FAST_XTAL]) |->
        !fast_rdy_r [*8] ##[1:12] fast_rdy_r)
        else $error("Fast ready timing wrong");
    a_wake_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_r != ST_RUN && wake_req) |=> (state_r == ST_RUN) && !cpu_hold)
        else $error("Wake did not return to run");
endmodule

/* File: rtl/power_mode_pkg.sv */
// Constants and types shared by the power-mode controller
package power_mode_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SYS_MODE = 8'h00;
    localparam logic [7:0] ADDR_WDT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_OPTIONS = 8'h0C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SM_DIV_LSB = 5;
    localparam int SM_SLOW_RDY = 3;
    localparam int SM_FAST_RDY = 2;
    localparam int SM_IDLE_EN = 1;
    localparam int SM_FAST_SEL = 0;
    localparam int WC_KEEP_SYS = 7;
    localparam int WC_PERIOD_LSB = 4;
    localparam int ST_PWR_DOWN = 0;
    localparam int ST_TO = 1;
    localparam int ST_STATE_LSB = 2;
    localparam int ST_ON_SLOW = 7;
    localparam int OP_VD_EN = 0;
    localparam int OP_WDT_SUB = 1;
    localparam int OP_FAST_XTAL = 2;
    localparam int OP_SLOW_XTAL = 3;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic IDLE_EN_RST = 1'b1;
    localparam logic FAST_SEL_RST = 1'b1;
    localparam logic KEEP_SYS_RST = 1'b0;
    localparam logic [2:0] PERIOD_RST = 3'h7;
    localparam logic [3:0] WDT_EN_RST = 4'hA;
    localparam logic [3:0] WDT_OFF_CODE = 4'hA;
    localparam logic [3:0] OPT_RST = 4'hE;
    // Divider codes at or above this one select the divided fast clock
    localparam logic [2:0] DIV_FIRST_FAST = 3'h2;

    // ------------------------------------------------------------
    // Settling counts, in clock cycles (upper end of each range)
    // ------------------------------------------------------------
    localparam logic [10:0] FAST_XTAL_CYC = 11'h400;
    localparam logic [10:0] FAST_RC_CYC = 11'h010;
    localparam logic [10:0] SLOW_XTAL_CYC = 11'h400;
    localparam logic [10:0] SLOW_RC_CYC = 11'h002;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_DEEP_SLEEP = 5'h02,
        ST_LIGHT_SLEEP = 5'h04,
        ST_IDLE_STOP = 5'h08,
        ST_IDLE_RUN = 5'h10
    } pm_state_e;
endpackage

/* File: testbench/power_mode_controller_bench.sv */
// Self-checking bench for the power-mode controller
`timescale 1ns/10ps
`define CHK(g, e, m) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("ERROR %0t %s", $time, m); \
        end \
    end
module power_mode_controller_bench import power_mode_pkg::*;;
    logic ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, seed, mon_exp, mon_msk;
    logic halt_exec, wake_req, wdt_clear_instr, wdt_timeout;
    logic fast_osc_en, slow_osc_en, fast_div_taps_en, sysclk_on_slow;
    logic [2:0] sysclk_div_sel, dv;
    logic sysclk_run, timebase_clk_run, sub_clk_run, wdt_clk_run;
    logic wdt_clear, cpu_hold, io_hold, deep, watchdog_control_register;
    logic [3:0] code;
    logic [4:0] c;
    pm_state_e st;
    logic [31:0] exp_q[$], msk_q[$];
    int error_cnt = 0;
    int samples_checked = 0;
    // Bits: idle, keep sysclk, watchdog on, detector on, watchdog on sub
    localparam logic [4:0] cfgs [7] = '{5'h00, 5'h02, 5'h05, 5'h14,
                                        5'h15, 5'h1C, 5'h18};

    power_mode_controller power_mode_controller_inst (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .halt_exec(halt_exec), .wake_req(wake_req),
        .wdt_clear_instr(wdt_clear_instr), .wdt_timeout(wdt_timeout),
        .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
        .fast_div_taps_en(fast_div_taps_en),
        .sysclk_on_slow(sysclk_on_slow), .sysclk_div_sel(sysclk_div_sel),
        .sysclk_run(sysclk_run), .timebase_clk_run(timebase_clk_run),
        .sub_clk_run(sub_clk_run), .wdt_clk_run(wdt_clk_run),
        .wdt_clear(wdt_clear), .cpu_hold(cpu_hold), .io_hold(io_hold));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic wb_xfer(input logic we, input logic [7:0] adr,
        input logic [31:0] dat, input logic [3:0] sel,
        output logic [31:0] q);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        // Only the watchdog process ends a wait that never sees ack
        do
            @(posedge ref_clk);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb_xfer(1'b1, adr, dat, 4'hF, q);
    endtask

    task automatic wb_read(input logic [7:0] adr, input logic [31:0] e,
        input logic [31:0] m, output logic [31:0] q);
        exp_q.push_back(e);
        msk_q.push_back(m);
        wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF, q);
    endtask

    // Polls a flag with a bounded number of reads
    task automatic poll(input logic [7:0] adr, input int b, input logic v);
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            wb_read(adr, 32'h0000_0000, 32'h0000_0000, q);
            n++;
        end
        while (q[b] !== v && n < 600);
        `CHK(q[b], v, "flag never reached")
    endtask

    task automatic pulse(input int k);
        @(posedge ref_clk);
        halt_exec <= (k == 0);
        wake_req <= (k == 1);
        wdt_clear_instr <= (k == 2);
        wdt_timeout <= (k == 3);
        @(posedge ref_clk);
        halt_exec <= 1'b0;
        wake_req <= 1'b0;
        wdt_clear_instr <= 1'b0;
        wdt_timeout <= 1'b0;
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Read-data monitor: oldest note against each read answer
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
        begin
            mon_exp = exp_q.pop_front();
            mon_msk = msk_q.pop_front();
            `CHK(wb_dat_o & mon_msk, mon_exp & mon_msk, "read data")
        end
    end

    initial
    begin
        repeat (30000) @(posedge ref_clk);
        error_cnt++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        {halt_exec, wake_req, wdt_clear_instr, wdt_timeout} = 4'h0;
        seed = 32'h0000_bfb4;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wb_read(ADDR_SYS_MODE, 32'h0000_0003, 32'h0000_00F3, rd);
        wb_read(ADDR_WDT_CTRL, 32'h0000_007A, 32'hFFFF_FFFF, rd);
        wb_read(ADDR_STATUS, 32'h0000_0004, 32'hFFFF_FFFF, rd);
        wb_read(ADDR_OPTIONS, 32'h0000_000E, 32'hFFFF_FFFF, rd);
        pulse(1);
        #1 `CHK(cpu_hold, 1'b0, "wake in run")
        seed = lfsr(seed);
        wb_write(8'h10, seed);
        wb_read(8'h10, 32'h0000_0000, 32'hFFFF_FFFF, rd);
        wb_xfer(1'b1, ADDR_WDT_CTRL, seed, 4'hE, rd);
        wb_read(ADDR_WDT_CTRL, 32'h0000_007A, 32'hFFFF_FFFF, rd);
        seed = lfsr(seed);
        code = (seed[3:0] == WDT_OFF_CODE) ? 4'h5 : seed[3:0];
        wb_write(ADDR_WDT_CTRL, {24'h0, 1'b0, seed[6:4], code});
        wb_read(ADDR_WDT_CTRL, {24'h0, 1'b0, seed[6:4], code},
            32'hFFFF_FFFF, rd);
        wb_write(ADDR_OPTIONS, 32'h0000_0000);
        poll(ADDR_SYS_MODE, SM_FAST_RDY, 1'b1);
        for (int d = 7; d >= 0; d--)
        begin
            dv = d[2:0];
            wb_write(ADDR_SYS_MODE, {24'h0, dv, 5'h00});
            poll(ADDR_STATUS, ST_ON_SLOW, dv < DIV_FIRST_FAST);
            `CHK(sysclk_on_slow, dv < DIV_FIRST_FAST, "source")
            `CHK(sysclk_div_sel, dv, "divider copy")
            if (dv < DIV_FIRST_FAST)
            begin
                `CHK(fast_osc_en, 1'b0, "fast osc on")
                `CHK(fast_div_taps_en, 1'b0, "taps on")
                wb_read(ADDR_SYS_MODE, 32'h8, 32'h8, rd);
            end
        end
        wb_write(ADDR_SYS_MODE, 32'h0000_0001);
        poll(ADDR_STATUS, ST_ON_SLOW, 1'b0);
        `CHK(fast_osc_en, 1'b1, "fast osc off")
        for (int i = 0; i < 7; i++)
        begin
            c = cfgs[i];
            wb_write(ADDR_OPTIONS, {30'h0, c[0], c[1]});
            wb_write(ADDR_WDT_CTRL,
                {24'h0, c[3], 3'h7, (c[2] ? code : WDT_OFF_CODE)});
            wb_write(ADDR_SYS_MODE, {30'h0, c[4], 1'b1});
            poll(ADDR_SYS_MODE, SM_FAST_RDY, 1'b1);
            pulse(3);
            wb_read(ADDR_STATUS, 32'h2, 32'h2, rd);
            st = !c[4] ? ((c[2] | c[1]) ? ST_LIGHT_SLEEP : ST_DEEP_SLEEP)
                : (c[3] ? ST_IDLE_RUN : ST_IDLE_STOP);
            deep = (st == ST_DEEP_SLEEP);
            watchdog_control_register = c[2] & (c[0] | (c[4] & c[3]));
            pulse(0);
            #1 `CHK(cpu_hold, 1'b1, "cpu hold")
            `CHK(io_hold, 1'b1, "io hold")
            `CHK(wdt_clear, 1'b1, "wdt clear")
            `CHK(sysclk_run, c[4] & c[3], "sysclk")
            `CHK(timebase_clk_run, c[4], "timebase")
            `CHK(sub_clk_run, !deep, "sub clock")
            `CHK(wdt_clk_run, watchdog_control_register, "wdt clock")
            `CHK(slow_osc_en, !deep, "slow osc")
            `CHK(fast_osc_en, c[4] & c[3], "fast osc")
            `CHK(sysclk_div_sel, 3'h0, "divider kept")
            // A second halt while asleep must not restart anything
            pulse(0);
            #1 `CHK(wdt_clear, 1'b0, "wdt clear width")
            wb_read(ADDR_STATUS, {24'h0, 1'b0, st, 2'b01},
                32'hFFFF_FFFF, rd);
            if (deep)
                wb_read(ADDR_SYS_MODE, 32'h0, 32'h8, rd);
            pulse(1);
            #1 `CHK(cpu_hold, 1'b0, "wake")
            pulse(2);
            wb_read(ADDR_STATUS, 32'h4, 32'hFFFF_FFFF, rd);
        end
        // Crystal fast oscillator: slow source kept until fast settles
        wb_write(ADDR_OPTIONS, 32'h0000_0004);
        wb_write(ADDR_SYS_MODE, 32'h0000_0000);
        poll(ADDR_STATUS, ST_ON_SLOW, 1'b1);
        wb_write(ADDR_SYS_MODE, 32'h0000_0001);
        repeat (1000) @(posedge ref_clk);
        wb_read(ADDR_STATUS, 32'h0000_0084, 32'hFFFF_FFFF, rd);
        wb_read(ADDR_SYS_MODE, 32'h0000_0000, 32'h0000_0004, rd);
        poll(ADDR_SYS_MODE, SM_FAST_RDY, 1'b1);
        poll(ADDR_STATUS, ST_ON_SLOW, 1'b0);
        print_verdict();
    end
endmodule
